// *** logic/ocr_config_regs.sv ***
// overcurrent and current-sense amplifier configuration bank on APB
// assumes APB master on clk_sys; detector inputs synchronous to clk_sys
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module ocr_config_regs #(
  parameter int RETRY_LONG_CYCLES = ocr_pkg::RETRY_LONG_CYC   // shorten in simulation
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output wire logic [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  input  wire logic        drain_source_overcurrent,
  input  wire logic        shunt_overcurrent,
  input  wire logic        pwm_new_cycle,
  output wire logic        retry_interval_sel,
  output wire logic [4:0]  dead_band_cycles,
  output wire logic [1:0]  overcurrent_response_sel,
  output wire logic [1:0]  overcurrent_filter_sel,
  output wire logic [3:0]  drain_source_threshold_sel,
  output wire logic        amp_input_source_sel,
  output wire logic        ref_halving_sel,
  output wire logic        low_side_sense_ref_sel,
  output wire logic [1:0]  amp_gain_sel,
  output wire logic        shunt_fault_disable,
  output wire logic        amp_a_offset_cal,
  output wire logic        amp_b_offset_cal,
  output wire logic        amp_c_offset_cal,
  output wire logic [1:0]  shunt_trip_level_sel,
  output wire logic        cal_method_sel,
  output wire logic        gate_shutdown,
  output wire logic [1:0]  fault_report,
  output wire logic        irq
);
  localparam logic [ocr_pkg::RETRY_CW-1:0] RETRY_LONG  = ocr_pkg::RETRY_CW'(RETRY_LONG_CYCLES);
  localparam logic [ocr_pkg::RETRY_CW-1:0] RETRY_SHORT = ocr_pkg::RETRY_CW'(ocr_pkg::RETRY_SHORT_CYC);

  ////////////////////////////////////////////////////////////////////////
  // storage
  logic [10:0] ocp_ff;     // overcurrent_protection_control
  logic [10:0] csa_ff;     // current_sense_amp_control
  logic [10:0] cal_ff;     // amp_calibration_config
  logic        cbc_ff;     // cycle_clear_enable
  logic [1:0]  sts_ff;     // sticky events: bit0 drain-source, bit1 shunt
  logic [1:0]  mask_ff;    // interrupt enables, same layout
  logic [10:0] nxt_csa;

  ////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, unmapped index answers with pslverr
  wire [5:0] idx      = paddr[7:2];
  wire       acc      = psel && penable;
  wire       wr       = acc && pwrite;
  wire       hit_aux  = (idx == ocr_pkg::IDX_AUX);
  wire       hit_ocp  = (idx == ocr_pkg::IDX_OCP);
  wire       hit_csa  = (idx == ocr_pkg::IDX_CSA);
  wire       hit_cal  = (idx == ocr_pkg::IDX_CAL);
  wire       hit_sts  = (idx == ocr_pkg::IDX_STS);
  wire       hit_mask = (idx == ocr_pkg::IDX_MASK);
  wire       hit_st   = (idx == ocr_pkg::IDX_STATE);
  wire       mapped   = hit_aux || hit_ocp || hit_csa || hit_cal || hit_sts || hit_mask || hit_st;
  wire       wr_ocp   = wr && hit_ocp;
  wire       wr_csa   = wr && hit_csa;
  wire       wr_cal   = wr && hit_cal;
  wire       wr_aux   = wr && hit_aux;
  wire       wr_sts   = wr && hit_sts;
  wire       wr_mask  = wr && hit_mask;
  // fault clear is a pulse from writing one; it is not stored
  wire       clear_req = wr_aux && pwdata[ocr_pkg::AUX_CLR];

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  ////////////////////////////////////////////////////////////////////////
  // selecting the phase node as amplifier input drags the sense ref along
  assign nxt_csa = pwdata[ocr_pkg::CSA_SRC] ? (pwdata[10:0] | 11'h100) : pwdata[10:0];  // RQ9

  // configuration registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ocp_ff <= ocr_pkg::RST_OCP;   // RQ8
      csa_ff <= ocr_pkg::RST_CSA;   // RQ10 RQ12 RQ15
      cal_ff <= ocr_pkg::RST_CAL;   // RQ16
      cbc_ff <= ocr_pkg::RST_CBC;
    end else begin
      if (wr_ocp) begin
        ocp_ff <= pwdata[10:0];     // RQ18
      end
      if (wr_csa) begin
        csa_ff <= nxt_csa;
      end
      if (wr_cal) begin
        cal_ff <= pwdata[10:0];     // reserved bits kept as written
      end
      if (wr_aux) begin
        cbc_ff <= pwdata[ocr_pkg::AUX_CBC];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field outputs straight from the register bits
  assign retry_interval_sel         = ocp_ff[ocr_pkg::OCP_RETRY];
  assign overcurrent_response_sel   = ocp_ff[ocr_pkg::OVERCURRENT_RESPONSE_SEL +: 2];
  assign overcurrent_filter_sel     = ocp_ff[ocr_pkg::OVERCURRENT_FILTER_SEL +: 2];
  assign drain_source_threshold_sel = ocp_ff[3:0];
  assign amp_input_source_sel       = csa_ff[ocr_pkg::CSA_SRC];
  assign ref_halving_sel            = csa_ff[ocr_pkg::CSA_HALF];    // RQ10
  assign low_side_sense_ref_sel     = csa_ff[ocr_pkg::CSA_LSREF];   // RQ11
  assign amp_gain_sel               = csa_ff[ocr_pkg::AMP_GAIN_SEL +: 2];  // RQ12
  assign shunt_fault_disable        = csa_ff[ocr_pkg::CSA_DIS];
  assign amp_a_offset_cal           = csa_ff[ocr_pkg::CSA_CALA];    // RQ14
  assign amp_b_offset_cal           = csa_ff[ocr_pkg::CSA_CALB];    // RQ14
  assign amp_c_offset_cal           = csa_ff[ocr_pkg::CSA_CALC];    // RQ14
  assign shunt_trip_level_sel       = csa_ff[1:0];                  // RQ15
  assign cal_method_sel             = cal_ff[0];                    // RQ16

  ////////////////////////////////////////////////////////////////////////
  // dead band: least time, rounded up to whole cycles
  function automatic logic [4:0] dead_cyc(input int ns);
    dead_cyc = 5'((ns * ocr_pkg::CLK_MHZ + 999) / 1000);
  endfunction : dead_cyc

  wire [1:0] dead_code = ocp_ff[ocr_pkg::OCP_DEAD +: 2];
  assign dead_band_cycles = (dead_code == 2'b00) ? dead_cyc(ocr_pkg::DEAD_NS[0]) :   // RQ2
                            (dead_code == 2'b01) ? dead_cyc(ocr_pkg::DEAD_NS[1]) :
                            (dead_code == 2'b10) ? dead_cyc(ocr_pkg::DEAD_NS[2]) :
                                                   dead_cyc(ocr_pkg::DEAD_NS[3]);

  // persistence window in cycles for the selected filter code
  wire [ocr_pkg::DEG_CW-1:0] deg_target =
    ocr_pkg::DEG_CW'(ocr_pkg::DEG_US[overcurrent_filter_sel] * ocr_pkg::CLK_MHZ);  // RQ7

  // retry interval applies to both fault sources
  wire [ocr_pkg::RETRY_CW-1:0] retry_cycles = retry_interval_sel ? RETRY_SHORT : RETRY_LONG;  // RQ1

  ////////////////////////////////////////////////////////////////////////
  // detector chains; a disabled shunt fault never reaches its filter
  wire shunt_raw = shunt_overcurrent && !shunt_fault_disable;   // RQ13
  wire ds_qual;
  wire sh_qual;
  wire ds_flag;
  wire sh_flag;
  wire ds_shut;
  wire sh_shut;
  wire ds_event;
  wire sh_event;

  ocr_deglitch #(.CW(ocr_pkg::DEG_CW)) u_deg_ds (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .raw     (drain_source_overcurrent),
    .target  (deg_target),
    .qual    (ds_qual)
  );

  ocr_deglitch #(.CW(ocr_pkg::DEG_CW)) u_deg_sh (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .raw     (shunt_raw),
    .target  (deg_target),
    .qual    (sh_qual)
  );

  ocr_fault_ch u_ch_ds (
    .clk_sys            (clk_sys),
    .nrst               (nrst),
    .trip               (ds_qual),
    .mode               (overcurrent_response_sel),
    .cycle_clear_enable (cbc_ff),
    .pwm_new_cycle      (pwm_new_cycle),
    .clear_req          (clear_req),
    .retry_cycles       (retry_cycles),
    .fault_flag         (ds_flag),
    .shutdown           (ds_shut),
    .event_pulse        (ds_event)
  );

  ocr_fault_ch u_ch_sh (
    .clk_sys            (clk_sys),
    .nrst               (nrst),
    .trip               (sh_qual),
    .mode               (overcurrent_response_sel),
    .cycle_clear_enable (cbc_ff),
    .pwm_new_cycle      (pwm_new_cycle),
    .clear_req          (clear_req),
    .retry_cycles       (retry_cycles),
    .fault_flag         (sh_flag),
    .shutdown           (sh_shut),
    .event_pulse        (sh_event)
  );

  assign gate_shutdown = ds_shut || sh_shut;   // RQ3 RQ4
  assign fault_report  = {sh_flag, ds_flag};

  ////////////////////////////////////////////////////////////////////////
  // interrupt status: a new event wins over a write-one clear in one cycle
  wire [1:0] evt     = {sh_event, ds_event};
  wire [1:0] w1c     = wr_sts ? pwdata[1:0] : 2'b00;
  wire [1:0] nxt_sts = (sts_ff & ~w1c) | evt;

  // status and mask registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sts_ff  <= 2'b00;
      mask_ff <= 2'b00;
    end else begin
      sts_ff <= nxt_sts;
      if (wr_mask) begin
        mask_ff <= pwdata[1:0];
      end
    end
  end

  assign irq = |(sts_ff & mask_ff);

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped reads return zero
  assign prdata = hit_aux  ? {31'h0000_0000, cbc_ff} :
                  hit_ocp  ? {21'h00_0000, ocp_ff} :
                  hit_csa  ? {21'h00_0000, csa_ff} :   // RQ18
                  hit_cal  ? {21'h00_0000, cal_ff} :
                  hit_sts  ? {30'h0000_0000, sts_ff} :
                  hit_mask ? {30'h0000_0000, mask_ff} :
                  hit_st   ? {29'h0000_0000, gate_shutdown, sh_flag, ds_flag} :
                             32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_ocp_write;
    psel && penable && pwrite && idx == ocr_pkg::IDX_OCP;
  endsequence

  a_ocp_readback : assert property (@(posedge clk_sys) disable iff (!nrst) // RQ18
    s_ocp_write |=> ocp_ff == $past(pwdata[10:0]))
    else $error("overcurrent register did not store write");
  a_src_forces_ref : assert property (@(posedge clk_sys) disable iff (!nrst) // RQ9
    amp_input_source_sel |-> low_side_sense_ref_sel)
    else $error("sense ref not forced with phase node source");
  a_shunt_silent : assert property (@(posedge clk_sys) disable iff (!nrst) // RQ13
    shunt_fault_disable && $past(shunt_fault_disable) |-> !sh_qual)
    else $error("shunt fault qualified while disabled");
  a_set_beats_clear : assert property (@(posedge clk_sys) disable iff (!nrst)
    ds_event |=> sts_ff[0])
    else $error("event lost against status clear");
  a_dead_band_map : assert property (@(posedge clk_sys) disable iff (!nrst) // RQ2
    dead_code == 2'b11 |-> dead_band_cycles == 5'd20)
    else $error("dead band count wrong for longest code");
  a_cbc_clears : assert property (@(posedge clk_sys) disable iff (!nrst) // RQ17
    ds_flag && overcurrent_response_sel == ocr_pkg::MODE_RETRY && cbc_ff && pwm_new_cycle |=> !ds_flag)
    else $error("cycle clear did not release retry fault");
endmodule : ocr_config_regs

// *** logic/ocr_deglitch.sv ***
// persistence filter for one raw overcurrent detector
// assumes the raw input is synchronous to clk_sys
`timescale 1ns/1ps
module ocr_deglitch #(
  parameter int CW = 9
) (
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  input  wire logic          raw,
  input  wire logic [CW-1:0] target,
  output wire logic          qual
);
  logic [CW-1:0] cnt_ff;   // cycles the condition has persisted
  logic [CW-1:0] nxt_cnt;

  ////////////////////////////////////////////////////////////////////////
  // any drop of the raw level restarts the count, so glitches never add up
  assign nxt_cnt = !raw ? '0 : (cnt_ff == target) ? cnt_ff : cnt_ff + 1'b1;  // RQ7
  assign qual    = raw && (cnt_ff == target);

  // counter register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // qualified only after the full persistence window
  a_qual_needs_history : assert property (@(posedge clk_sys) disable iff (!nrst) // RQ7
    $rose(qual) |-> $past(raw) && ($past(cnt_ff) == target - 1'b1))
    else $error("filter qualified before the window elapsed");
endmodule : ocr_deglitch

// *** logic/ocr_fault_ch.sv ***
// fault response for one overcurrent source: latch, retry, report or ignore
// assumes trip is a filtered level and pwm_new_cycle a one-cycle pulse
`timescale 1ns/1ps
module ocr_fault_ch (
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  input  wire logic                          trip,
  input  wire logic [1:0]                    mode,
  input  wire logic                          cycle_clear_enable,
  input  wire logic                          pwm_new_cycle,
  input  wire logic                          clear_req,
  input  wire logic [ocr_pkg::RETRY_CW-1:0]  retry_cycles,
  output wire logic                          fault_flag,
  output wire logic                          shutdown,
  output wire logic                          event_pulse
);
  ocr_pkg::ocr_state_type          state_ff;   // idle or faulted
  ocr_pkg::ocr_state_type          nxt_state;
  logic [ocr_pkg::RETRY_CW-1:0]    timer_ff;   // retry countdown
  logic [ocr_pkg::RETRY_CW-1:0]    nxt_timer;
  logic                            leave;      // condition that ends the fault

  ////////////////////////////////////////////////////////////////////////
  // mode 11 never enters a fault, so nothing is reported or acted on
  assign event_pulse = (state_ff == ocr_pkg::OCR_IDLE) && trip && (mode != ocr_pkg::MODE_OFF);  // RQ6

  // exit conditions per mode; a timer that ran down while latched must not
  // strand a fault once software switches the response to retry
  always_comb begin
    case (mode)
      ocr_pkg::MODE_LATCH:  leave = clear_req;                                   // RQ3
      ocr_pkg::MODE_RETRY:  leave = (timer_ff < 2) || (cycle_clear_enable && pwm_new_cycle);  // RQ4 RQ17
      ocr_pkg::MODE_REPORT: leave = clear_req;
      default:              leave = 1'b1;   // mode changed to off while faulted
    endcase
  end

  // state and timer next values
  always_comb begin
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    case (state_ff)
      ocr_pkg::OCR_IDLE: begin
        if (event_pulse) begin
          nxt_state = ocr_pkg::OCR_FAULT;
          nxt_timer = retry_cycles;   // RQ1
        end
      end
      ocr_pkg::OCR_FAULT: begin
        if (leave) begin
          nxt_state = ocr_pkg::OCR_IDLE;
        end
        if (timer_ff != 0) begin
          nxt_timer = timer_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = ocr_pkg::OCR_IDLE;
      end
    endcase
  end

  // registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ocr_pkg::OCR_IDLE;
      timer_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
    end
  end

  // report-only mode keeps the flag but never drives outputs off
  assign fault_flag = (state_ff == ocr_pkg::OCR_FAULT);
  assign shutdown   = fault_flag && !mode[1];   // RQ5

  a_latch_holds : assert property (@(posedge clk_sys) disable iff (!nrst) // RQ3
    fault_flag && mode == ocr_pkg::MODE_LATCH && !clear_req |=> fault_flag)
    else $error("latched fault cleared without a clear");
  a_retry_ends : assert property (@(posedge clk_sys) disable iff (!nrst) // RQ4
    fault_flag && mode == ocr_pkg::MODE_RETRY && timer_ff == 1 |=> !fault_flag)
    else $error("retry fault did not clear at timer end");
  a_report_no_act : assert property (@(posedge clk_sys) disable iff (!nrst) // RQ5
    mode[1] |-> !shutdown)
    else $error("shutdown asserted in report or off mode");
  a_off_silent : assert property (@(posedge clk_sys) disable iff (!nrst) // RQ6
    mode == ocr_pkg::MODE_OFF && $past(mode) == ocr_pkg::MODE_OFF |-> !event_pulse && !fault_flag)
    else $error("fault reported in off mode");
  a_retry_load : assert property (@(posedge clk_sys) disable iff (!nrst) // RQ1
    event_pulse |=> timer_ff == $past(retry_cycles))
    else $error("retry timer not loaded with selected interval");
endmodule : ocr_fault_ch

// *** logic/ocr_pkg.sv ***
// constants shared by the overcurrent / amplifier configuration bank
// assumes one 50 MHz clock and an APB master with 32-bit data
//
// Functional notes
// RQ1: retry select picks 8 ms or 50 us
// RQ2: dead-band code picks 50/100/200/400 ns
// RQ3: response 00 latches fault until cleared
// RQ4: response 01 auto-clears fault and retries
// RQ5: response 10 flags only, no output action
// RQ6: response 11 neither reports nor acts
// RQ7: filter code picks 1/2/4/8 us persistence
// RQ8: overcurrent register reset defaults as specified
// RQ9: source bit 1 also forces sense ref
// RQ10: reference halving bit, reset value one
// RQ11: sense ref picks low-side measurement path
// RQ12: gain code picks 5/10/20/40, reset 20
// RQ13: shunt disable bit suppresses shunt fault
// RQ14: per-channel bits short amplifier inputs
// RQ15: shunt trip code 0.25..1 V, reset 1 V
// RQ16: calibration method bit, manual at reset
// RQ17: cycle-clear in mode 01 clears on PWM
// RQ18: registers read back last written value; current_sense_amp_control reads bit 8 as one once bit 10 is written one
package ocr_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_AUX   = 6'h04;  // cycle-clear and fault clear
  localparam logic [5:0] IDX_OCP   = 6'h05;  // overcurrent_protection_control
  localparam logic [5:0] IDX_CSA   = 6'h06;  // current_sense_amp_control
  localparam logic [5:0] IDX_CAL   = 6'h07;  // amp_calibration_config
  localparam logic [5:0] IDX_STS   = 6'h08;  // sticky event status, write one to clear
  localparam logic [5:0] IDX_MASK  = 6'h09;  // interrupt mask
  localparam logic [5:0] IDX_STATE = 6'h0A;  // live fault state, read only
  localparam int REG_W = 11;                 // width of config registers
  // reset values
  localparam logic [10:0] RST_OCP  = 11'h169;  // 0 01 01 10 1001
  localparam logic [10:0] RST_CSA  = 11'h283;  // 0 1 0 10 0 000 11
  localparam logic [10:0] RST_CAL  = 11'h000;
  localparam logic        RST_CBC  = 1'b1;
  // field positions
  localparam int OCP_RETRY = 10;
  localparam int OCP_DEAD  = 8;   // [9:8]
  localparam int OVERCURRENT_RESPONSE_SEL  = 6;   // [7:6]
  localparam int OVERCURRENT_FILTER_SEL   = 4;   // [5:4]
  localparam int CSA_SRC   = 10;
  localparam int CSA_HALF  = 9;
  localparam int CSA_LSREF = 8;
  localparam int AMP_GAIN_SEL  = 6;   // [7:6]
  localparam int CSA_DIS   = 5;
  localparam int CSA_CALA  = 4;
  localparam int CSA_CALB  = 3;
  localparam int CSA_CALC  = 2;
  localparam int AUX_CBC   = 0;
  localparam int AUX_CLR   = 1;
  // response modes
  localparam logic [1:0] MODE_LATCH  = 2'b00;
  localparam logic [1:0] MODE_RETRY  = 2'b01;
  localparam logic [1:0] MODE_REPORT = 2'b10;
  localparam logic [1:0] MODE_OFF    = 2'b11;
  // timing, figures as printed then cycles at the clock rate
  localparam int CLK_MHZ = 50;
  localparam int DEAD_NS [4] = '{50, 100, 200, 400};
  localparam int DEG_US [4]  = '{1, 2, 4, 8};
  localparam int RETRY_SHORT_US = 50;
  localparam int RETRY_LONG_MS  = 8;
  localparam int RETRY_SHORT_CYC = RETRY_SHORT_US * CLK_MHZ;
  localparam int RETRY_LONG_CYC  = RETRY_LONG_MS * 1000 * CLK_MHZ;
  localparam int DEG_CW   = 9;    // filter counter width
  localparam int RETRY_CW = 19;   // retry counter width
  localparam int DEAD_CW  = 5;    // dead-band cycle count width
  // fault channel states, one-bit gray path
  typedef enum logic {OCR_IDLE = 1'b0, OCR_FAULT = 1'b1} ocr_state_type;
endpackage : ocr_pkg

// *** tb/ocr_config_regs_test.sv ***
// self-checking bench for the overcurrent / amplifier configuration bank
// assumes the bank answers APB with zero wait states and detectors are synchronous
`timescale 1ns/1ps
module ocr_config_regs_test;
  logic        clk_sys = 1'b0;   // 50 MHz system clock
  logic        nrst    = 1'b0;   // async reset, active low
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        ds      = 1'b0;   // raw drain-source detector
  logic        sh      = 1'b0;   // raw shunt detector
  logic        pwm     = 1'b0;   // new pwm input pulse
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, rsel, ain, rhalf, lsref, sdis, ca, cb, cc, calm, gsd, irq;
  wire logic [4:0]  dbc;
  wire logic [3:0]  vth;
  wire logic [1:0]  mode_o, filt, gain, strip, frep;
  int               err_count   = 0;
  int               comparisons = 0;
  logic [32:0]      rq[$];           // expected {pslverr, prdata} of reads
  logic [31:0]      seed = 32'd61;   // xorshift state
  logic [4:0]       dtab[4] = '{5'd3, 5'd5, 5'd10, 5'd20};  // dead band in cycles

  // short long-retry count keeps the run brief
  ocr_config_regs #(.RETRY_LONG_CYCLES(300)) ocr_config_regs_inst (
    .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drain_source_overcurrent(ds), .shunt_overcurrent(sh), .pwm_new_cycle(pwm),
    .retry_interval_sel(rsel), .dead_band_cycles(dbc), .overcurrent_response_sel(mode_o),
    .overcurrent_filter_sel(filt), .drain_source_threshold_sel(vth), .amp_input_source_sel(ain),
    .ref_halving_sel(rhalf), .low_side_sense_ref_sel(lsref), .amp_gain_sel(gain),
    .shunt_fault_disable(sdis), .amp_a_offset_cal(ca), .amp_b_offset_cal(cb), .amp_c_offset_cal(cc),
    .shunt_trip_level_sel(strip), .cal_method_sel(calm), .gate_shutdown(gsd),
    .fault_report(frep), .irq(irq));

  always #10 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  // xorshift source for write data
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  // one apb transfer; the request is held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rq.push_back(e);
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // raw detector high for 60 cycles, longer than the 50-cycle filter
  task automatic trip(input logic c);
    @(posedge clk_sys);
    if (c) sh <= 1'b1;
    else ds <= 1'b1;
    repeat (60) @(posedge clk_sys);
    ds <= 1'b0;
    sh <= 1'b0;
  endtask : trip

  // read results are judged at the access edge, oldest note first
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite && rq.size() > 0) chk({pslverr, prdata}, rq.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    logic [31:0] d;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    apb(1'b0, 8'h14, 0, {1'b0, 32'h0000_0169});
    apb(1'b0, 8'h18, 0, {1'b0, 32'h0000_0283});
    apb(1'b0, 8'h1C, 0, 33'h0);
    apb(1'b0, 8'h10, 0, 33'h1);
    apb(1'b0, 8'h3C, 0, {1'b1, 32'h0000_0000});
    @(negedge clk_sys);
    chk({gain, strip, rhalf, ain, lsref, calm}, {2'b10, 2'b11, 4'b1000});
    $display("reset values done");
    // source bit forces the sense reference bit
    for (i = 0; i < 2; i++) begin
      d = rnd() & 32'h0000_06FF;
      d[10] = i[0];
      apb(1'b1, 8'h18, d, 0);
      d[8] = d[8] | i[0];
      apb(1'b0, 8'h18, 0, {1'b0, d});
      @(negedge clk_sys);
      chk({ain, rhalf, lsref, gain, sdis, ca, cb, cc, strip}, d[10:0]);
    end
    d = rnd() & 32'h0000_07FF;
    apb(1'b1, 8'h1C, d, 0);
    apb(1'b0, 8'h1C, 0, {1'b0, d});
    @(negedge clk_sys);
    chk(calm, d[0]);
    $display("amplifier registers done");
    apb(1'b1, 8'h18, 32'h0000_0283, 0);
    apb(1'b1, 8'h24, 32'h0000_0003, 0);
    apb(1'b1, 8'h10, 32'h0000_0000, 0);
    // every response mode, each with its own dead-band code
    for (i = 0; i < 4; i++) begin
      d = (i << 8) | (i << 6) | (rnd() & 32'h0000_000F);
      apb(1'b1, 8'h14, d, 0);
      apb(1'b0, 8'h14, 0, {1'b0, d});
      @(negedge clk_sys);
      chk({dbc, mode_o, filt, vth, rsel}, {dtab[i], i[1:0], 2'b00, d[3:0], 1'b0});
      trip(1'b0);
      @(negedge clk_sys);
      chk({frep, gsd, irq}, {1'b0, i != 3, i < 2, i != 3});
      repeat (400) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(frep, {1'b0, i == 0 || i == 2});
      apb(1'b0, 8'h20, 0, {32'h0, i != 3});
      apb(1'b1, 8'h20, 32'h0000_0003, 0);
      apb(1'b1, 8'h10, 32'h0000_0002, 0);
      @(negedge clk_sys);
      chk({frep, irq}, 0);
    end
    $display("response modes done");
    apb(1'b1, 8'h14, 32'h0000_0440, 0);
    @(negedge clk_sys);
    chk(rsel, 1'b1);
    trip(1'b0);
    repeat (2470) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(frep, 2'b01);
    repeat (50) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(frep, 2'b00);
    apb(1'b1, 8'h10, 32'h0000_0001, 0);
    trip(1'b0);
    @(negedge clk_sys);
    chk(gsd, 1'b1);
    @(posedge clk_sys) pwm <= 1'b1;
    @(posedge clk_sys) pwm <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(gsd, 1'b0);
    // a 60-cycle trip is shorter than the 100-cycle window of filter code 01
    apb(1'b1, 8'h14, 32'h0000_0450, 0);
    @(negedge clk_sys);
    chk(filt, 2'b01);
    trip(1'b0);
    @(negedge clk_sys);
    chk(frep, 2'b00);
    apb(1'b1, 8'h14, 32'h0000_0440, 0);
    $display("retry timing done");
    apb(1'b1, 8'h18, 32'h0000_02A3, 0);
    trip(1'b1);
    @(negedge clk_sys);
    chk(frep, 2'b00);
    apb(1'b1, 8'h18, 32'h0000_0283, 0);
    trip(1'b1);
    @(negedge clk_sys);
    chk(frep, 2'b10);
    $display("shunt disable done");
    // reset again in mid-run: faults, status and registers return to defaults
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    chk({frep, gsd, irq}, 33'h0);
    apb(1'b0, 8'h14, 0, {1'b0, 32'h0000_0169});
    @(negedge clk_sys);
    chk(33'(rq.size()), 33'h0);
    $display("mid-run reset done");
    finish_test();
  end
endmodule : ocr_config_regs_test
